/* core/rwc_pkg.sv */
package rwc_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    // Power-on hold-off before the first instruction, in microseconds.
    localparam int unsigned POR_HOLD_US = 20_000;
    localparam int unsigned POR_HOLD_CYC = POR_HOLD_US * CLK_PER_US;
    // Internal oscillator recovery, in low power oscillator periods.
    localparam logic [1:0] WAKE_LP_LAST = 2'h2;
    localparam logic [1:0] WDT_LIMIT = 2'h3;

    // ==========================================================
    // Register port
    // ==========================================================
    localparam int unsigned ADDR_W = 9;
    localparam logic [8:0] OFS_TMR_CLK = 9'h031;
    localparam logic [8:0] OFS_INTERNAL_OSCILLATOR_TRIM = 9'h034;
    localparam logic [8:0] OFS_LOW_POWER_OSCILLATOR_TRIM = 9'h036;
    localparam logic [8:0] OFS_WDT_CLEAR = 9'h0e3;
    localparam logic [8:0] OFS_SCR = 9'h0ff;
    localparam logic [8:0] OFS_OSCILLATOR_CONTROL_0 = 9'h1e0;
    localparam logic [7:0] WDT_CLEAR_ALL = 8'h38;

    // ==========================================================
    // Reset values and write masks
    // ==========================================================
    // Gain reset value is arbitrary; boot code loads the calibrated value.
    localparam logic [4:0] INTERNAL_OSCILLATOR_GAIN_RST = 5'h10;
    localparam logic [2:0] INTERNAL_OSCILLATOR_OFFSET_RST = 3'h0;
    localparam logic [7:0] LOW_POWER_OSCILLATOR_TRIM_RST = 8'h00;
    localparam logic [7:0] LOW_POWER_OSCILLATOR_TRIM_MASK = 8'hbf;
    localparam logic [7:0] TMR_CLK_RST = 8'h8f;
    localparam logic [7:0] OSCILLATOR_CONTROL_0_RST = 8'h08;
    localparam logic [7:0] OSCILLATOR_CONTROL_0_MASK = 8'h3f;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned SCR_GLOBAL_IRQ_ENABLE_STATUS = 7;
    localparam int unsigned SCR_WATCHDOG_RESET_FLAG = 5;
    localparam int unsigned SCR_POWER_ON_RESET_FLAG = 4;
    localparam int unsigned SCR_SLEEP = 3;
    localparam int unsigned SCR_STOP = 0;
    localparam int unsigned CAP_DIV_LSB = 6;
    localparam int unsigned CAP_SRC_LSB = 4;
    localparam int unsigned SLP_SEL_LSB = 3;
    localparam logic [1:0] CAP_SRC_INTERNAL_OSCILLATOR = 2'h0;
    localparam logic [1:0] CAP_SRC_LOW_POWER_OSCILLATOR = 2'h2;

    // Sleep timer terminal counts in low power oscillator ticks (32768 Hz).
    localparam logic [14:0] SLP_TERM_512HZ = 15'h003f;
    localparam logic [14:0] SLP_TERM_64HZ = 15'h01ff;
    localparam logic [14:0] SLP_TERM_8HZ = 15'h0fff;
    localparam logic [14:0] SLP_TERM_1HZ = 15'h7fff;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        CPU_BOOT,
        CPU_RUN,
        CPU_SLEEP,
        CPU_WAKE,
        CPU_STOP
    } rwc_cpu_t;

    typedef struct packed {
        logic lp_mode;
        logic [1:0] lp_bias;
        logic [3:0] lp_freq;
        logic [2:0] internal_oscillator_offset;
        logic [4:0] internal_oscillator_gain;
    } rwc_trim_t;

    typedef struct packed {
        rwc_cpu_t cpu;
        logic [7:0] internal_oscillator_trim;
        logic [7:0] low_power_oscillator_trim;
        logic [7:0] tmr_clk;
        logic [7:0] oscillator_control_0;
        logic watchdog_reset_flag;
        logic power_on_reset_flag;
        logic sleep;
        logic stop;
        logic [2:0] lp_sync;
        logic [14:0] slp_cnt;
        logic [1:0] wdt_cnt;
        logic wdt_en;
        logic clr_wdt;
        logic clr_slp;
        logic [19:0] hold_cnt;
        logic [1:0] wake_cnt;
        logic [2:0] cap_cnt;
        logic cap_tick;
        logic slp_irq;
        logic watchdog_reset_event;
        logic [7:0] rdata;
    } rwc_state_t;

endpackage

/* core/rwc_sysctl.sv */
// Contract
// (RULE_01) Capture clock from fast or slow oscillator, divided
// (RULE_02) Offset trim bits add 7.5, 15, 30 kHz
// (RULE_03) Gain field scales each offset step size
// (RULE_04) Offset bits reset zero; gain loaded by boot
// (RULE_05) Low power bit selects reduced power slow oscillator
// (RULE_06) Software never writes bias trim pattern 10
// (RULE_07) Wake waits three slow oscillator periods
// (RULE_08) Any reset restores defaults, disables interrupts
// (RULE_09) After reset fetch from address zero
// (RULE_10) Power-on CPU clock is 24 MHz over eight
// (RULE_11) Hardware sets reset flags; software only clears
// (RULE_12) Status bit 7 mirrors global interrupt enable
// (RULE_13) Sleep bit sleeps CPU until interrupt pending
// (RULE_14) Stop bit halts CPU until reset
// (RULE_15) Power-on loads status register with 0x10
// (RULE_16) CPU held off 20 ms after power-on
// (RULE_17) Watchdog starts when power-on flag cleared
// (RULE_18) Sleep timer overflow raises sleep interrupt
// (RULE_19) Watchdog resets after three timer overflows
// (RULE_20) Clear write resets watchdog; 0x38 also timer
// (RULE_21) Sleep select picks 512, 64, 8, 1 Hz
// (RULE_22) Capture divider and source field encodings
// (RULE_23) Watchdog clears applied on slow oscillator ticks
`timescale 1ns/1ps
`default_nettype none

module rwc_sysctl #(
    parameter int unsigned POR_HOLD_CYCLES = rwc_pkg::POR_HOLD_CYC
) (
    // Clock and power-on reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [rwc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Oscillator pin and CPU status
    input wire logic low_power_oscillator_clk_in,
    input wire logic global_irq_enable_in,
    input wire logic irq_pending_in,
    // CPU control
    output logic cpu_hold_out,
    output logic cpu_reset_out,
    output logic irq_disable_out,
    output logic [15:0] reset_vector_out,
    output logic [2:0] cpu_speed_out,
    // Oscillators and timers
    output logic internal_oscillator_enable_out,
    output logic internal_oscillator_ready_out,
    output logic capture_timer_clock_out,
    output logic sleep_irq_out,
    output logic watchdog_reset_event_out,
    output rwc_pkg::rwc_trim_t trim_out
);
    import rwc_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    localparam rwc_state_t ST_POR = '{
        cpu: CPU_BOOT,
        internal_oscillator_trim: {INTERNAL_OSCILLATOR_OFFSET_RST, INTERNAL_OSCILLATOR_GAIN_RST},
        low_power_oscillator_trim: LOW_POWER_OSCILLATOR_TRIM_RST,
        tmr_clk: TMR_CLK_RST,
        oscillator_control_0: OSCILLATOR_CONTROL_0_RST,
        power_on_reset_flag: 1'b1,
        default: '0
    };
    localparam logic [19:0] HOLD_LAST = 20'(POR_HOLD_CYCLES - 1);

    rwc_state_t s_r;
    rwc_state_t s_nxt;
    logic lp_tick;
    logic slp_ovf;
    logic src_tick;
    logic [14:0] slp_term;
    logic [1:0] cap_src;
    logic [2:0] cap_last;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        s_nxt = s_r;
        s_nxt.cap_tick = 1'b0;
        s_nxt.slp_irq = 1'b0;
        s_nxt.watchdog_reset_event = 1'b0;
        s_nxt.rdata = 8'h00;

        // The first stage feeds only the second; edges are taken downstream.
        s_nxt.lp_sync = {s_r.lp_sync[1:0], low_power_oscillator_clk_in};
        lp_tick = s_r.lp_sync[1] & ~s_r.lp_sync[2];

        unique case (s_r.oscillator_control_0[SLP_SEL_LSB +: 2]) // [RULE_21]
            2'h0: slp_term = SLP_TERM_512HZ;
            2'h1: slp_term = SLP_TERM_64HZ;
            2'h2: slp_term = SLP_TERM_8HZ;
            2'h3: slp_term = SLP_TERM_1HZ;
        endcase

        // Capture clock: the system clock stands in for the fast oscillator,
        // which is stopped while the CPU sleeps.
        cap_src = s_r.tmr_clk[CAP_SRC_LSB +: 2];
        cap_last = {s_r.tmr_clk[CAP_DIV_LSB +: 2], 1'b1};
        src_tick = 1'b0;
        if (cap_src == CAP_SRC_INTERNAL_OSCILLATOR) begin // [RULE_22]
            src_tick = (s_r.cpu != CPU_SLEEP);
        end else if (cap_src == CAP_SRC_LOW_POWER_OSCILLATOR) begin
            src_tick = lp_tick;
        end
        if (src_tick) begin // [RULE_01]
            if (s_r.cap_cnt >= cap_last) begin
                s_nxt.cap_cnt = 3'h0;
                s_nxt.cap_tick = 1'b1;
            end else begin
                s_nxt.cap_cnt = s_r.cap_cnt + 3'h1;
            end
        end

        // Sleep timer and watchdog advance only on slow oscillator ticks.
        slp_ovf = 1'b0;
        if (lp_tick) begin
            if (s_r.clr_slp) begin // [RULE_23]
                s_nxt.slp_cnt = 15'h0000;
            end else if (s_r.slp_cnt >= slp_term) begin
                s_nxt.slp_cnt = 15'h0000;
                slp_ovf = 1'b1;
            end else begin
                s_nxt.slp_cnt = s_r.slp_cnt + 15'h0001;
            end
            if (s_r.clr_wdt) begin // [RULE_23]
                s_nxt.wdt_cnt = 2'h0;
            end else if (slp_ovf && s_r.wdt_en && s_r.wdt_cnt != WDT_LIMIT) begin // [RULE_19]
                s_nxt.wdt_cnt = s_r.wdt_cnt + 2'h1;
            end
            s_nxt.clr_wdt = 1'b0;
            s_nxt.clr_slp = 1'b0;
        end
        s_nxt.slp_irq = slp_ovf; // [RULE_18]

        // Once the power-on flag is clear the watchdog cannot be stopped.
        s_nxt.wdt_en = s_r.wdt_en | ~s_r.power_on_reset_flag; // [RULE_17]

        // Register reads, answered one cycle later.
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_TMR_CLK: s_nxt.rdata = s_r.tmr_clk;
                OFS_INTERNAL_OSCILLATOR_TRIM: s_nxt.rdata = s_r.internal_oscillator_trim;
                OFS_LOW_POWER_OSCILLATOR_TRIM: s_nxt.rdata = s_r.low_power_oscillator_trim;
                OFS_OSCILLATOR_CONTROL_0: s_nxt.rdata = s_r.oscillator_control_0;
                OFS_SCR: begin
                    s_nxt.rdata[SCR_GLOBAL_IRQ_ENABLE_STATUS] = global_irq_enable_in; // [RULE_12]
                    s_nxt.rdata[SCR_WATCHDOG_RESET_FLAG] = s_r.watchdog_reset_flag;
                    s_nxt.rdata[SCR_POWER_ON_RESET_FLAG] = s_r.power_on_reset_flag;
                    s_nxt.rdata[SCR_SLEEP] = s_r.sleep;
                    s_nxt.rdata[SCR_STOP] = s_r.stop;
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // Register writes.
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_TMR_CLK: s_nxt.tmr_clk = reg_wdata_in; // [RULE_22]
                OFS_INTERNAL_OSCILLATOR_TRIM: s_nxt.internal_oscillator_trim = reg_wdata_in; // [RULE_02] [RULE_03]
                OFS_LOW_POWER_OSCILLATOR_TRIM: s_nxt.low_power_oscillator_trim = reg_wdata_in & LOW_POWER_OSCILLATOR_TRIM_MASK; // [RULE_05]
                OFS_OSCILLATOR_CONTROL_0: s_nxt.oscillator_control_0 = reg_wdata_in & OSCILLATOR_CONTROL_0_MASK;
                OFS_WDT_CLEAR: begin
                    // The clear waits for the next slow tick so both counters
                    // change on the same edge they count on.
                    s_nxt.clr_wdt = 1'b1; // [RULE_20]
                    if (reg_wdata_in == WDT_CLEAR_ALL) begin
                        s_nxt.clr_slp = 1'b1; // [RULE_20]
                    end
                end
                OFS_SCR: begin
                    s_nxt.watchdog_reset_flag = s_r.watchdog_reset_flag & reg_wdata_in[SCR_WATCHDOG_RESET_FLAG]; // [RULE_11]
                    s_nxt.power_on_reset_flag = s_r.power_on_reset_flag & reg_wdata_in[SCR_POWER_ON_RESET_FLAG]; // [RULE_11]
                    s_nxt.sleep = reg_wdata_in[SCR_SLEEP];
                    s_nxt.stop = reg_wdata_in[SCR_STOP];
                end
                default: ;
            endcase
        end

        // CPU run control.
        unique case (s_r.cpu)
            CPU_BOOT: begin
                s_nxt.hold_cnt = s_r.hold_cnt + 20'h00001;
                if (s_r.hold_cnt >= HOLD_LAST) begin // [RULE_16]
                    s_nxt.cpu = CPU_RUN;
                end
            end
            CPU_RUN: begin
                if (s_r.stop) begin
                    s_nxt.cpu = CPU_STOP; // [RULE_14]
                end else if (s_r.sleep) begin
                    s_nxt.cpu = CPU_SLEEP; // [RULE_13]
                end
            end
            CPU_SLEEP: begin
                if (irq_pending_in) begin // [RULE_13]
                    s_nxt.cpu = CPU_WAKE;
                    s_nxt.wake_cnt = 2'h0;
                end
            end
            CPU_WAKE: begin
                if (lp_tick) begin // [RULE_07]
                    if (s_r.wake_cnt == WAKE_LP_LAST) begin
                        s_nxt.cpu = CPU_RUN;
                        s_nxt.sleep = 1'b0;
                    end else begin
                        s_nxt.wake_cnt = s_r.wake_cnt + 2'h1;
                    end
                end
            end
            CPU_STOP: s_nxt.cpu = CPU_STOP; // [RULE_14]
        endcase

        // A watchdog reset restores every register and records its cause;
        // it overrides any write in the same cycle, so the flag set wins.
        if (s_r.wdt_en && s_r.wdt_cnt == WDT_LIMIT && !s_r.power_on_reset_flag) begin // [RULE_19] [RULE_17]
            s_nxt.watchdog_reset_event = 1'b1;
            s_nxt.cpu = CPU_RUN; // [RULE_09]
            s_nxt.internal_oscillator_trim = {INTERNAL_OSCILLATOR_OFFSET_RST, INTERNAL_OSCILLATOR_GAIN_RST}; // [RULE_08] [RULE_04]
            s_nxt.low_power_oscillator_trim = LOW_POWER_OSCILLATOR_TRIM_RST; // [RULE_08]
            s_nxt.tmr_clk = TMR_CLK_RST;
            s_nxt.oscillator_control_0 = OSCILLATOR_CONTROL_0_RST;
            s_nxt.sleep = 1'b0;
            s_nxt.stop = 1'b0;
            s_nxt.power_on_reset_flag = 1'b0;
            s_nxt.watchdog_reset_flag = 1'b1; // [RULE_11]
            s_nxt.wdt_cnt = 2'h0;
            s_nxt.clr_wdt = 1'b0;
            s_nxt.clr_slp = 1'b0;
            s_nxt.cap_cnt = 3'h0;
        end
    end

    // ==========================================================
    // Register stage
    // ==========================================================
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= ST_POR; // [RULE_15] [RULE_08] [RULE_04]
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata_out = s_r.rdata;
    assign cpu_hold_out = (s_r.cpu != CPU_RUN);
    assign cpu_reset_out = (s_r.cpu == CPU_BOOT) | s_r.watchdog_reset_event; // [RULE_08]
    assign irq_disable_out = (s_r.cpu == CPU_BOOT) | s_r.watchdog_reset_event; // [RULE_08]
    assign reset_vector_out = RESET_VECTOR; // [RULE_09]
    assign cpu_speed_out = s_r.oscillator_control_0[2:0]; // [RULE_10]
    assign internal_oscillator_enable_out = (s_r.cpu != CPU_SLEEP);
    assign internal_oscillator_ready_out = (s_r.cpu != CPU_SLEEP) && (s_r.cpu != CPU_WAKE); // [RULE_07]
    assign capture_timer_clock_out = s_r.cap_tick;
    assign sleep_irq_out = s_r.slp_irq;
    assign watchdog_reset_event_out = s_r.watchdog_reset_event;
    assign trim_out.lp_mode = s_r.low_power_oscillator_trim[7]; // [RULE_05]
    assign trim_out.lp_bias = s_r.low_power_oscillator_trim[5:4];
    assign trim_out.lp_freq = s_r.low_power_oscillator_trim[3:0];
    assign trim_out.internal_oscillator_offset = s_r.internal_oscillator_trim[7:5]; // [RULE_02]
    assign trim_out.internal_oscillator_gain = s_r.internal_oscillator_trim[4:0]; // [RULE_03]

endmodule

`default_nettype wire

/* tb/rwc_sysctl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rwc_sysctl_monitor
    import rwc_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [rwc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // CPU side
    input wire logic global_irq_enable_in,
    input wire logic irq_pending_in,
    input wire logic cpu_hold_out,
    input wire logic cpu_reset_out,
    input wire logic irq_disable_out,
    input wire logic [15:0] reset_vector_out,
    input wire logic internal_oscillator_enable_out,
    input wire logic internal_oscillator_ready_out,
    input wire logic sleep_irq_out,
    input wire logic watchdog_reset_event_out
);
    // ==========================================================
    // Sequences
    // ==========================================================
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence scr_wr(logic [7:0] m, logic [7:0] v);
        reg_wr_in && reg_addr_in == OFS_SCR && (reg_wdata_in & m) == v && !cpu_hold_out;
    endsequence
    sequence rd_at(logic [8:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    // ==========================================================
    // Assertions
    // ==========================================================
    vector_zero_a: assert property (reset_vector_out == 16'h0000)
        else $error("reset vector not zero");
    reset_irq_tie_a: assert property (cpu_reset_out == irq_disable_out)
        else $error("interrupt disable not tied to cpu reset");
    wdr_pulse_a: assert property (watchdog_reset_event_out |=> !watchdog_reset_event_out)
        else $error("watchdog reset pulse too long");
    irq_pulse_a: assert property (sleep_irq_out |=> !sleep_irq_out)
        else $error("sleep interrupt pulse too long");
    wo_read_a: assert property (rd_at(OFS_WDT_CLEAR) |=> reg_rdata_out == 8'h00)
        else $error("watchdog clear register readable");
    gie_mirror_a: assert property (rd_at(OFS_SCR) |=> reg_rdata_out[7] == $past(global_irq_enable_in)
        && (reg_rdata_out & 8'h46) == 8'h00) else $error("status bit 7 does not mirror enable");
    sleep_entry_a: assert property (scr_wr(8'h09, 8'h08) |-> ##2 cpu_hold_out && !internal_oscillator_enable_out)
        else $error("sleep not entered");
    sleep_stay_a: assert property (!internal_oscillator_enable_out && !irq_pending_in |=> !internal_oscillator_enable_out || watchdog_reset_event_out)
        else $error("woke without pending interrupt");
    stop_hold_a: assert property (scr_wr(8'h01, 8'h01) |-> ##2 cpu_hold_out [*8])
        else $error("stop did not halt cpu");
    wake_start_a: assert property (!internal_oscillator_enable_out && irq_pending_in |=>
        (internal_oscillator_enable_out && !internal_oscillator_ready_out) [*8]) else $error("wake recovery too short");
endmodule
bind rwc_sysctl rwc_sysctl_monitor rwc_sysctl_monitor_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .global_irq_enable_in(global_irq_enable_in),
    .irq_pending_in(irq_pending_in), .cpu_hold_out(cpu_hold_out), .cpu_reset_out(cpu_reset_out),
    .irq_disable_out(irq_disable_out), .reset_vector_out(reset_vector_out),
    .internal_oscillator_enable_out(internal_oscillator_enable_out), .internal_oscillator_ready_out(internal_oscillator_ready_out), .sleep_irq_out(sleep_irq_out),
    .watchdog_reset_event_out(watchdog_reset_event_out));
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rwc_pkg::*;
    typedef struct packed {logic [8:0] addr; logic [7:0] wdata; logic [7:0] rdata;} rwc_row_t;
    logic clk_in, rstn_in, reg_wr_in, reg_rd_in, low_power_oscillator_clk_in, global_irq_enable_in, irq_pending_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, rd_val;
    logic cpu_hold_out, cpu_reset_out, irq_disable_out, internal_oscillator_enable_out, internal_oscillator_ready_out;
    logic capture_timer_clock_out, sleep_irq_out, watchdog_reset_event_out;
    logic [15:0] reset_vector_out;
    logic [2:0] cpu_speed_out;
    rwc_trim_t trim_out;
    int num_errors = 0;
    int checks = 0;
    int cap_n = 0;
    int irq_n = 0;
    int wdr_n = 0;
    int n, m;
    // Bias is only ever written as 11 or 01; pattern 10 may stop the oscillator.
    rwc_row_t rows [9] = '{'{9'h034, 8'ha5, 8'ha5}, '{9'h036, 8'hff, 8'hbf}, '{9'h036, 8'h1a, 8'h1a},
        '{9'h031, 8'h00, 8'h00}, '{9'h031, 8'hff, 8'hff}, '{9'h1e0, 8'hff, 8'h3f},
        '{9'h0e3, 8'h12, 8'h00}, '{9'h100, 8'hff, 8'h00}, '{9'h0ff, 8'hf6, 8'h10}};

    rwc_sysctl #(.POR_HOLD_CYCLES(20)) rwc_sysctl_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .low_power_oscillator_clk_in(low_power_oscillator_clk_in), .global_irq_enable_in(global_irq_enable_in),
        .irq_pending_in(irq_pending_in), .cpu_hold_out(cpu_hold_out), .cpu_reset_out(cpu_reset_out),
        .irq_disable_out(irq_disable_out), .reset_vector_out(reset_vector_out), .cpu_speed_out(cpu_speed_out),
        .internal_oscillator_enable_out(internal_oscillator_enable_out), .internal_oscillator_ready_out(internal_oscillator_ready_out),
        .capture_timer_clock_out(capture_timer_clock_out), .sleep_irq_out(sleep_irq_out),
        .watchdog_reset_event_out(watchdog_reset_event_out), .trim_out(trim_out));

    // ==========================================================
    // Clocks, event counters and tasks
    // ==========================================================
    // The slow oscillator runs far faster than 32 kHz to keep the run short.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        low_power_oscillator_clk_in = 1'b0;
        forever #200 low_power_oscillator_clk_in = ~low_power_oscillator_clk_in;
    end
    always @(posedge clk_in) begin
        cap_n <= cap_n + int'(capture_timer_clock_out);
        irq_n <= irq_n + int'(sleep_irq_out);
        wdr_n <= wdr_n + int'(watchdog_reset_event_out);
    end
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [8:0] a);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 rd_val = reg_rdata_out;
    endtask
    task do_reset;
        rstn_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
    endtask
    task end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_in);
        num_errors++;
        end_of_test;
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rstn_in, reg_wr_in, reg_rd_in, global_irq_enable_in, irq_pending_in} = '0;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        do_reset;
        #1 check("irq_disable", irq_disable_out, 1'b1);
        check("vector", reset_vector_out, 16'h0000);
        check("speed", cpu_speed_out, 3'h0);
        rd(OFS_SCR);
        check("status", rd_val, 8'h10);
        rd(OFS_INTERNAL_OSCILLATOR_TRIM);
        check("offset", rd_val[7:5], 3'h0);
        rd(OFS_TMR_CLK);
        check("tmr_clk", rd_val, TMR_CLK_RST);
        rd(OFS_OSCILLATOR_CONTROL_0);
        check("oscillator_control_0", rd_val, 8'h08);
        check("boot_hold", cpu_hold_out, 1'b1);
        repeat (25) @(posedge clk_in);
        #1 check("boot_done", cpu_hold_out, 1'b0);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            check("reg", rd_val, rows[i].rdata);
            if (i == 0) check("internal_oscillator", {trim_out.internal_oscillator_offset, trim_out.internal_oscillator_gain}, 8'ha5);
            if (i == 1) check("lp_mode", trim_out.lp_mode, 1'b1);
        end
        check("low_power_oscillator", {trim_out.lp_mode, trim_out.lp_bias, trim_out.lp_freq}, 7'h1a);
        global_irq_enable_in <= 1'b1;
        rd(OFS_SCR);
        check("gie", rd_val, 8'h90);
        global_irq_enable_in <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            wr(OFS_TMR_CLK, {d[1:0], 6'h0f});
            n = cap_n;
            repeat (96) @(posedge clk_in);
            m = 48 / (d + 1);
            check("cap_fast", (cap_n - n >= m - 1) && (cap_n - n <= m + 1), 1'b1);
        end
        wr(OFS_TMR_CLK, 8'h2f);
        n = cap_n;
        repeat (200) @(posedge clk_in);
        check("cap_slow", (cap_n - n >= 9) && (cap_n - n <= 11), 1'b1);
        wr(OFS_TMR_CLK, 8'h3f);
        n = cap_n;
        repeat (96) @(posedge clk_in);
        check("cap_off", cap_n - n, 16'h0);
        wr(OFS_OSCILLATOR_CONTROL_0, 8'h00);
        n = irq_n;
        m = wdr_n;
        repeat (2600) @(posedge clk_in);
        check("slp_irq", (irq_n - n >= 3) && (irq_n - n <= 5), 1'b1);
        check("wdt_off", wdr_n - m, 16'h0);
        // The power-on flag is written back as one so the watchdog stays off until its own test.
        wr(OFS_SCR, 8'h18);
        repeat (50) @(posedge clk_in);
        #1 check("asleep", {cpu_hold_out, internal_oscillator_enable_out}, 2'b10);
        irq_pending_in <= 1'b1;
        n = 0;
        while (!(internal_oscillator_ready_out && !cpu_hold_out) && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        irq_pending_in <= 1'b0;
        check("wake_time", n > 20 && n < 200, 1'b1);
        rd(OFS_SCR);
        check("woke", rd_val, 8'h10);
        wr(OFS_SCR, 8'h00);
        m = wdr_n;
        for (int k = 0; k < 6; k++) begin
            repeat (400) @(posedge clk_in);
            wr(OFS_WDT_CLEAR, k[0] ? WDT_CLEAR_ALL : 8'h01);
        end
        check("wdt_fed", wdr_n - m, 16'h0);
        n = 0;
        while (wdr_n == m && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        check("wdt_fire", n > 1280 && n < 3000, 1'b1);
        repeat (2) @(posedge clk_in);
        rd(OFS_SCR);
        check("wdr_flag", rd_val, 8'h20);
        rd(OFS_OSCILLATOR_CONTROL_0);
        check("wdr_dflt", rd_val, 8'h08);
        wr(OFS_SCR, 8'h01);
        repeat (40) @(posedge clk_in);
        #1 check("stopped", cpu_hold_out, 1'b1);
        do_reset;
        rd(OFS_SCR);
        check("por_again", rd_val, 8'h10);
        end_of_test;
    end
endmodule
`default_nettype wire
